// [rtl/epc_top.sv]
// data eeprom program control: row latch, programming sequencer, low power and interrupt, AXI4-Lite slave
// What this block does
// [RL1] latch mode on: array writes fill 16 latches
// [RL2] program start writes all latched bytes together
// [RL3] software keeps row fixed; last write wins
// [RL4] cycle end clears both bits, raises interrupt
// [RL5] rewrite ANDs; latches clear at end, fall
// [RL6] latch contents can never be read back
// [RL7] array read in latch mode: zero data, SLVERR response
// [RL8] array write in read mode is ignored
// [RL9] wait entered now, or after running cycle
// [RL10] done interrupt wakes wait, not halt
// [RL11] halt stops at once, abandons cycle
// [RL12] interrupt needs enable and cpu mask clear
// [RL13] control resets 00h, bits 7:3 read 0
// [RL14] pending request clears on service entry
// [RL15] latch mode clear only while program idle
// [RL16] program bit reads 1 while cycle runs
// [RL17] array read answers within one clock
// [RL18] cycle length timed inside the block
// [RL19] cycle length is a clock count parameter
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
module epc_top #(
	parameter int unsigned PROG_CYCLES = epc_pkg::PROG_CYCLES_DEF
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [epc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [epc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [epc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [epc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpu_irq_mask,
	input wire logic isr_enter,
	input wire logic wait_for_irq_instr,
	input wire logic halt_instr,
	input wire logic ext_wake,
	output logic irq,
	output logic in_wait,
	output logic in_halt
);
	import epc_pkg::*;

	function automatic epc_sel_t decode(input logic [ADDR_W-1:0] a);
		epc_sel_t s;
		s = SEL_NONE;
		if (a[ADDR_W-1:ADDR_W-2] == ARR_REGION)
			s = SEL_ARR;
		else if (a == OFS_CTRL)
			s = SEL_CTRL;
		else if (a == OFS_IRQ_STS)
			s = SEL_STS;
		else if (a == OFS_IRQ_MSK)
			s = SEL_MSK;
		else if (a == OFS_PWR)
			s = SEL_PWR;
		return s;
	endfunction

	// write and read channel holding registers
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [1:0] rresp_reg;

	// block state
	logic ie_reg;
	logic lat_reg;
	logic lat_next;
	epc_prog_t prog_reg;
	epc_prog_t prog_next;
	logic [31:0] cnt_reg;
	logic [7:0] latch_reg [LATCH_N];
	logic [LATCH_N-1:0] lvalid_reg;
	logic [3:0] row_reg;
	logic [7:0] mem [ARR_BYTES];
	logic sts_reg;
	logic sts_next;
	logic msk_reg;
	epc_pwr_t pwr_reg;
	epc_pwr_t pwr_next;
	logic wpend_reg;
	logic wpend_next;

	wire epc_sel_t wsel = decode(awaddr_reg);
	wire epc_sel_t rsel = decode(s_axi_araddr);
	wire logic wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	wire logic rd_fire = s_axi_arvalid & ~rvalid_reg;
	wire logic wr_en8 = wr_fire & wstrb0_reg;
	wire logic ctrl_wr = wr_en8 & (wsel == SEL_CTRL);
	wire logic sts_w1c = wr_en8 & (wsel == SEL_STS) & wdata_reg[BIT_DONE];
	wire logic running = (prog_reg == PS_PROG);
	wire logic [7:0] wbyte_idx = awaddr_reg[9:2];
	wire logic [3:0] lidx = wbyte_idx[3:0];
	wire logic arr_wr = wr_en8 & (wsel == SEL_ARR) & lat_reg; // [RL8]
	wire logic halt_abort = running & halt_instr; // [RL11]
	wire logic sw_abort = running & ctrl_wr & ~wdata_reg[BIT_PGM];
	wire logic prog_end = running & ~halt_abort & ~sw_abort & (cnt_reg == PROG_CYCLES - 1); // [RL18] [RL19]
	wire logic start = ~running & ctrl_wr & wdata_reg[BIT_PGM] & lat_reg & ~halt_instr & (pwr_reg != PW_HALT); // [RL2] [RL16]
	wire logic lat_fall = lat_reg & ~lat_next;
	wire logic latch_clr = prog_end | lat_fall; // [RL5]
	wire logic done_evt = prog_end & ie_reg; // [RL4]
	wire logic [7:0] ctrl_rd = {5'h00, ie_reg, lat_reg, running}; // [RL13] [RL16]
	wire logic arr_rd_blocked = lat_reg; // [RL7]

	assign s_axi_awready = ~aw_hold_reg;
	assign s_axi_wready = ~w_hold_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign irq = sts_reg & msk_reg & ie_reg & ~cpu_irq_mask; // [RL12]
	assign in_wait = (pwr_reg == PW_WAIT);
	assign in_halt = (pwr_reg == PW_HALT);

	always_comb
	begin
		if (prog_end | halt_abort)
			lat_next = 1'b0; // [RL4] [RL11]
		else if (ctrl_wr & wdata_reg[BIT_LAT])
			lat_next = 1'b1; // [RL1]
		else if (ctrl_wr & ~running)
			lat_next = 1'b0; // [RL15]
		else
			lat_next = lat_reg;
	end

	always_comb
	begin
		if (prog_end | halt_abort | sw_abort)
			prog_next = PS_IDLE; // [RL4]
		else if (start)
			prog_next = PS_PROG;
		else
			prog_next = prog_reg;
	end

	// set wins over both clears
	assign sts_next = done_evt | (sts_reg & ~sts_w1c & ~isr_enter); // [RL14]

	always_comb
	begin
		pwr_next = pwr_reg;
		wpend_next = wpend_reg;
		case (pwr_reg)
			PW_RUN:
			begin
				if (halt_instr)
				begin
					pwr_next = PW_HALT; // [RL11]
					wpend_next = 1'b0;
				end
				else if (wait_for_irq_instr | wpend_reg)
				begin
					if (running & ~prog_end)
						wpend_next = 1'b1; // [RL9]
					else
					begin
						pwr_next = PW_WAIT; // [RL9]
						wpend_next = 1'b0;
					end
				end
			end
			PW_WAIT:
			begin
				if (halt_instr)
					pwr_next = PW_HALT;
				else if (irq | ext_wake)
					pwr_next = PW_RUN; // [RL10]
			end
			PW_HALT:
			begin
				if (ext_wake)
					pwr_next = PW_RUN; // [RL10]
			end
			default:
			begin
				pwr_next = PW_RUN;
				wpend_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			awaddr_reg <= 12'h000;
		end
		else if (s_axi_awvalid & ~aw_hold_reg)
		begin
			aw_hold_reg <= 1'b1;
			awaddr_reg <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_hold_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_hold_reg <= 1'b0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
		end
		else if (s_axi_wvalid & ~w_hold_reg)
		begin
			w_hold_reg <= 1'b1;
			wdata_reg <= s_axi_wdata[7:0];
			wstrb0_reg <= s_axi_wstrb[0];
		end
		else if (wr_fire)
			w_hold_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (wsel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	// read answer registered one clock after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg <= RESP_OKAY;
			case (rsel)
				SEL_CTRL: rdata_reg <= {24'h000000, ctrl_rd};
				SEL_STS: rdata_reg <= {31'h0, sts_reg};
				SEL_MSK: rdata_reg <= {31'h0, msk_reg};
				SEL_PWR: rdata_reg <= {29'h0, wpend_reg, in_halt, in_wait};
				SEL_ARR:
				begin
					rdata_reg <= arr_rd_blocked ? 32'h0000_0000 : {24'h000000, mem[s_axi_araddr[9:2]]}; // [RL17] [RL7]
					rresp_reg <= arr_rd_blocked ? RESP_SLVERR : RESP_OKAY; // [RL7]
				end
				default:
				begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= RESP_DECERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ie_reg <= CTRL_RESET[BIT_IE]; // [RL13]
			lat_reg <= CTRL_RESET[BIT_LAT];
			prog_reg <= PS_IDLE;
			sts_reg <= 1'b0;
			msk_reg <= 1'b0;
			pwr_reg <= PW_RUN;
			wpend_reg <= 1'b0;
		end
		else
		begin
			if (ctrl_wr)
				ie_reg <= wdata_reg[BIT_IE];
			if (wr_en8 & (wsel == SEL_MSK))
				msk_reg <= wdata_reg[BIT_DONE];
			lat_reg <= lat_next;
			prog_reg <= prog_next;
			sts_reg <= sts_next;
			pwr_reg <= pwr_next;
			wpend_reg <= wpend_next;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_reg <= 32'h0000_0000;
		else if (running & ~prog_end)
			cnt_reg <= cnt_reg + 32'h0000_0001; // [RL18]
		else
			cnt_reg <= 32'h0000_0000;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			row_reg <= 4'h0;
		else if (arr_wr)
			row_reg <= wbyte_idx[7:4]; // [RL3]
	end

	// one byte latch per row position; no read path exists for them
	genvar gi;
	generate
		for (gi = 0; gi < LATCH_N; gi++)
		begin : g_latch
			wire logic hit = arr_wr & (lidx == 4'(gi));
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					latch_reg[gi] <= 8'h00;
					lvalid_reg[gi] <= 1'b0;
				end
				else if (latch_clr | halt_abort)
				begin
					latch_reg[gi] <= 8'h00; // [RL5] [RL6]
					lvalid_reg[gi] <= 1'b0;
				end
				else if (hit)
				begin
					latch_reg[gi] <= lvalid_reg[gi] ? (latch_reg[gi] & wdata_reg) : wdata_reg; // [RL1] [RL5]
					lvalid_reg[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// latched bytes of the row committed in the clock the cycle ends
	always_ff @(posedge aclk)
	begin
		if (prog_end)
		begin
			for (int i = 0; i < LATCH_N; i++)
			begin
				if (lvalid_reg[i])
					mem[{row_reg, i[3:0]}] <= latch_reg[i]; // [RL2]
			end
		end
	end

endmodule // epc_top

// [rtl/epc_pkg.sv]
// constants, register map and types for the nonvolatile program control block
package epc_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned LATCH_N = 16;
	localparam int unsigned ARR_BYTES = 256;
	localparam int unsigned PROG_CYCLES_DEF = 1000;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_PWR = 12'h00C;
	localparam logic [1:0] ARR_REGION = 2'h1;
	localparam int unsigned BIT_PGM = 0;
	localparam int unsigned BIT_LAT = 1;
	localparam int unsigned BIT_IE = 2;
	localparam int unsigned BIT_DONE = 0;
	localparam int unsigned BIT_WAIT = 0;
	localparam int unsigned BIT_HALT = 1;
	localparam int unsigned BIT_WPEND = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [2:0] {SEL_CTRL, SEL_STS, SEL_MSK, SEL_PWR, SEL_ARR, SEL_NONE} epc_sel_t;
	typedef enum logic {PS_IDLE, PS_PROG} epc_prog_t;
	typedef enum logic [1:0] {PW_RUN, PW_WAIT, PW_HALT} epc_pwr_t;
endpackage

// [tb/epc_top_sva.sv]
// port assertions for the program control block
module epc_top_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [epc_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpu_irq_mask,
	input wire logic isr_enter,
	input wire logic halt_instr,
	input wire logic ext_wake,
	input wire logic irq,
	input wire logic in_wait,
	input wire logic in_halt
);
	timeunit 1ns;
	timeprecision 1ps;
	import epc_pkg::*;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence woken;
		in_wait && irq;
	endsequence
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
	irq_gate_a: assert property (cpu_irq_mask |-> !irq) else $error("irq while cpu masked");
	isr_clear_a: assert property (isr_enter |=> !irq) else $error("irq kept after service entry");
	halt_enter_a: assert property (halt_instr |=> in_halt) else $error("halt not entered");
	halt_stay_a: assert property (in_halt && !ext_wake |=> in_halt) else $error("halt left early");
	wait_exit_a: assert property (woken |-> ##[1:2] !in_wait) else $error("wait not left on irq");
endmodule // epc_top_sva

bind epc_top epc_top_sva u_epc_top_sva (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .cpu_irq_mask, .isr_enter, .halt_instr, .ext_wake, .irq, .in_wait, .in_halt);

// [tb/epc_cpu_model.sv]
// cpu side bus master issuing AXI4-Lite reads and writes
module epc_cpu_model (
	input wire logic aclk,
	output logic [epc_pkg::ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [epc_pkg::DATA_W-1:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [epc_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [epc_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	import epc_pkg::*;
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
	end
	// handshakes and answers are sampled at the rising edge itself, before the design updates
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] r);
		logic b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		b = 1'h0;
		while (!b)
		begin
			@(posedge aclk);
			if (s_axi_awvalid & s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid & s_axi_wready)
				s_axi_wvalid <= 1'h0;
			b = s_axi_bvalid;
			r = s_axi_bresp;
		end
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ok;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		ok = 1'h0;
		while (!ok)
		begin
			@(posedge aclk);
			if (s_axi_arvalid & s_axi_arready)
				s_axi_arvalid <= 1'h0;
			ok = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
		end
		s_axi_rready <= 1'h0;
	endtask
endmodule // epc_cpu_model

// [tb/epc_top_tb.sv]
// self-checking bench for the program control block
module epc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import epc_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic cpu_irq_mask = 1'h0;
	logic [3:0] ev = 4'h0;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, in_wait, in_halt;
	int miscompares = 0;
	int num_checks = 0;
	always #2 aclk = ~aclk;
	epc_top #(.PROG_CYCLES(8)) u_epc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.cpu_irq_mask, .isr_enter(ev[0]), .wait_for_irq_instr(ev[1]), .halt_instr(ev[2]), .ext_wake(ev[3]),
		.irq, .in_wait, .in_halt);
	epc_cpu_model u_epc_cpu_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task rc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		u_epc_cpu_model.rd(a, d, r);
		chk($sformatf("addr %h", a), d, e);
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
		u_epc_cpu_model.wr(a, v, r);
		chk($sformatf("wresp %h", a), 32'(r), 32'(RESP_OKAY));
	endtask
	task pulse(input int k);
		@(posedge aclk);
		ev[k] <= 1'h1;
		@(posedge aclk);
		ev[k] <= 1'h0;
		@(negedge aclk);
	endtask
	task automatic till(ref logic s);
		for (int i = 0; i < 60 && s !== 1'h1; i++) @(negedge aclk);
	endtask
	task end_sim;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		miscompares++;
		end_sim;
	end
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		rc(OFS_CTRL, 32'h0);
		u_epc_cpu_model.rd(12'h100, d, r);
		chk("unmapped resp", 32'(r), 32'(RESP_DECERR));
		wr(OFS_CTRL, 8'hFF);
		rc(OFS_CTRL, 32'h6);
		u_epc_cpu_model.rd(12'h480, d, r);
		chk("blocked resp", 32'(r), 32'(RESP_SLVERR));
		chk("blocked data", d, 32'h0);
		wr(12'h480, 8'hF3);
		wr(12'h480, 8'h3C);
		wr(12'h484, 8'h5A);
		wr(OFS_CTRL, 8'h07);
		pulse(1);
		chk("early wait", 32'(in_wait), 32'h0);
		rc(OFS_CTRL, 32'h7);
		till(in_wait);
		chk("in wait", 32'(in_wait), 32'h1);
		rc(OFS_CTRL, 32'h4);
		rc(OFS_IRQ_STS, 32'h1);
		wr(OFS_IRQ_MSK, 8'h01);
		@(negedge aclk);
		chk("woken", 32'(in_wait), 32'h0);
		chk("irq", 32'(irq), 32'h1);
		rc(12'h480, 32'h30);
		rc(12'h484, 32'h5A);
		pulse(2);
		repeat (3) @(negedge aclk);
		chk("halted", 32'(in_halt), 32'h1);
		pulse(3);
		chk("unhalted", 32'(in_halt), 32'h0);
		@(posedge aclk);
		cpu_irq_mask <= 1'h1;
		@(negedge aclk);
		chk("masked irq", 32'(irq), 32'h0);
		@(posedge aclk);
		cpu_irq_mask <= 1'h0;
		pulse(0);
		chk("serviced irq", 32'(irq), 32'h0);
		wr(OFS_CTRL, 8'h04);
		wr(12'h484, 8'h00);
		wr(OFS_CTRL, 8'h06);
		wr(12'h480, 8'h0F);
		wr(OFS_CTRL, 8'h07);
		till(irq);
		rc(12'h480, 32'h0F);
		rc(12'h484, 32'h5A);
		wr(OFS_IRQ_STS, 8'h01);
		@(negedge aclk);
		chk("cleared irq", 32'(irq), 32'h0);
		u_epc_cpu_model.wr(12'h100, 8'h01, r);
		chk("unmapped wresp", 32'(r), 32'(RESP_DECERR));
		pulse(1);
		chk("idle wait", 32'(in_wait), 32'h1);
		rc(OFS_PWR, 32'h1);
		pulse(3);
		rc(OFS_PWR, 32'h0);
		wr(OFS_CTRL, 8'h06);
		wr(12'h488, 8'h11);
		wr(OFS_CTRL, 8'h07);
		pulse(2);
		chk("halt abort", 32'(in_halt), 32'h1);
		pulse(3);
		rc(OFS_CTRL, 32'h4);
		rc(OFS_IRQ_STS, 32'h0);
		wr(OFS_CTRL, 8'h06);
		wr(12'h488, 8'hF0);
		wr(OFS_CTRL, 8'h07);
		wr(OFS_CTRL, 8'h05);
		rc(OFS_CTRL, 32'h7);
		till(irq);
		rc(12'h488, 32'hF0);
		wr(OFS_IRQ_STS, 8'h01);
		wr(OFS_CTRL, 8'h06);
		wr(12'h488, 8'h3C);
		wr(OFS_CTRL, 8'h04);
		wr(OFS_CTRL, 8'h06);
		wr(12'h488, 8'h0F);
		wr(OFS_CTRL, 8'h07);
		till(irq);
		rc(12'h488, 32'h0F);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(negedge aclk);
		chk("reset irq", 32'(irq), 32'h0);
		rc(OFS_CTRL, 32'h0);
		rc(OFS_IRQ_STS, 32'h0);
		end_sim;
	end
endmodule // epc_top_tb
